// [hdl/bcp_parser.sv]
// Purpose: Online command interpreter for auto setup, reference codes and sensors.
// Assumes: Command bytes and label characters come from logic on i_clock.
// Notes: Reference banks are swapped only when an RS command or a learned label ends well.
`timescale 1ns/1ps
module bcp_parser (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Command bytes, i_rx_last marks the final byte of a command.
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_last,
    // Decoded label characters, held until acknowledged.
    input wire logic i_lbl_valid,
    input wire logic i_lbl_first,
    input wire logic i_lbl_last,
    input wire logic i_lbl_bad,
    input wire logic [7:0] i_lbl_char,
    input wire logic [3:0] i_lbl_type,
    input wire logic [6:0] i_lbl_digits,
    output logic o_lbl_ack,
    // Types enabled by the setup menus.
    input wire logic [15:0] i_setup_types,
    // Answer bytes.
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    input wire logic i_tx_ready,
    // Modes and simulated sensors.
    output logic o_sensor1,
    output logic o_sensor2,
    output logic o_auto_active,
    output logic o_learn_active,
    output logic o_commit,
    output logic [15:0] o_type_mask,
    // Reference codes.
    output logic [3:0] o_ref1_type,
    output logic [4:0] o_ref1_len,
    output logic [3:0] o_ref2_type,
    output logic [4:0] o_ref2_len,
    output logic o_work_sel,
    input wire logic i_ref_rd_sel,
    input wire logic [4:0] i_ref_rd_idx,
    output logic [7:0] o_ref_rd_data
);
    typedef struct packed {
        bcp_pkg::bcp_pst_t ps;
        logic [7:0] first;
        logic rs_sel;
        logic [3:0] rs_tens;
        logic [3:0] rs_type;
        logic [5:0] rs_cnt;
        logic auto_on;
        logic [15:0] mask;
        logic [15:0] prev_mask;
        logic commit;
        logic learn_on;
        logic learn_sel;
        logic learn_done;
        logic detect;
        logic s1;
        logic s2;
        logic [1:0] map1;
        logic [1:0] map2;
        logic [4:0] len1;
        logic [4:0] len2;
        logic [3:0] typ1;
        logic [3:0] typ2;
        logic work_sel;
        logic tx_valid;
        logic [7:0] tx_data;
        logic ack;
        bcp_pkg::bcp_fst_t fs;
        logic hdr;
        logic keep;
        logic store;
        logic [5:0] cnt;
        logic [3:0] ltype;
        logic [6:0] ldig;
    } bcp_state_t;

    bcp_state_t s_r, s_nxt;
    logic [7:0] u;
    logic txfree, start, take, we, allowed, cc_hit;
    logic [6:0] waddr, raddr, tval;
    logic [7:0] wdata;
    logic [1:0] spare;

    // One ASCII decimal digit of a value, tens or ones.
    function automatic logic [7:0] bcp_dig(input logic [6:0] v, input logic hi);
        logic [6:0] q;
        q = hi ? v / 7'd10 : v % 7'd10;
        return bcp_pkg::CH_ZERO + {1'b0, q};
    endfunction : bcp_dig

    // Letters are folded so that lower case commands work alike.
    assign u = (i_rx_data >= 8'h61 && i_rx_data <= 8'h7A) ? i_rx_data - 8'h20 : i_rx_data;
    assign txfree = !s_r.tx_valid || i_tx_ready;
    assign start = s_r.fs == bcp_pkg::F_IDLE && i_lbl_valid && i_lbl_first && !s_r.ack;
    assign take = s_r.fs == bcp_pkg::F_BODY && i_lbl_valid && !s_r.ack && (txfree || !s_r.keep);
    assign allowed = s_r.mask[i_lbl_type] || i_setup_types[i_lbl_type];
    assign cc_hit = i_rx_valid && i_rx_last && s_r.ps == bcp_pkg::P_L2
                    && {s_r.first, u} == bcp_pkg::CODE_DETECT_CMD;
    assign tval = 7'(s_r.rs_tens) * 7'd10 + 7'(u[3:0]);
    assign spare = (s_r.map1 != 2'h0 && s_r.map2 != 2'h0) ? 2'h0 :
                   (s_r.map1 != 2'h1 && s_r.map2 != 2'h1) ? 2'h1 :
                   (s_r.map1 != 2'h2 && s_r.map2 != 2'h2) ? 2'h2 : 2'h3;
    // New codes go to the spare bank so a broken entry never touches a stored code.
    assign we = (s_r.ps == bcp_pkg::P_RSD && i_rx_valid && s_r.rs_cnt < 6'(bcp_pkg::REF_MAX))
                || (take && s_r.store && s_r.cnt < 6'(bcp_pkg::REF_MAX));
    assign waddr = {spare, s_r.ps == bcp_pkg::P_RSD ? s_r.rs_cnt[4:0] : s_r.cnt[4:0]};
    assign wdata = s_r.ps == bcp_pkg::P_RSD ? i_rx_data : i_lbl_char;
    assign raddr = {i_ref_rd_sel ? s_r.map2 : s_r.map1, i_ref_rd_idx};

    bcp_ref_mem #(.AW(7), .DW(8)) u_mem (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_we(we),
        .i_waddr(waddr),
        .i_wdata(wdata),
        .i_raddr(raddr),
        .o_rdata(o_ref_rd_data)
    );

    // Command parser and label formatter share one next-state process.
    always_comb begin
        s_nxt = s_r;
        s_nxt.commit = 1'b0;
        s_nxt.ack = 1'b0;
        if (s_r.tx_valid && i_tx_ready) begin
            s_nxt.tx_valid = 1'b0;
        end
        if (i_rx_valid) begin
            // Any unexpected byte skips to the end of the command and changes nothing.
            s_nxt.ps = i_rx_last ? bcp_pkg::P_IDLE : bcp_pkg::P_SKIP;
            case (s_r.ps)
                bcp_pkg::P_IDLE: begin
                    if (!i_rx_last && (u == bcp_pkg::CH_C || u == bcp_pkg::CH_R)) begin
                        s_nxt.first = u;
                        s_nxt.ps = bcp_pkg::P_L2;
                    end else if (i_rx_last && u == bcp_pkg::CH_PLUS) begin
                        s_nxt.s1 = 1'b1;
                    end else if (i_rx_last && u == bcp_pkg::CH_MINUS) begin
                        s_nxt.s1 = 1'b0;
                    end else if (i_rx_last && u == bcp_pkg::CH_S2_ON) begin
                        s_nxt.s2 = 1'b1;
                    end else if (i_rx_last && u == bcp_pkg::CH_S2_OFF) begin
                        s_nxt.s2 = 1'b0;
                    end
                end
                bcp_pkg::P_L2: begin
                    if ({s_r.first, u} == bcp_pkg::CODE_DETECT_CMD && i_rx_last) begin
                        s_nxt.detect = 1'b1;
                    end else if (!i_rx_last && {s_r.first, u} == bcp_pkg::AUTO_SETUP_CMD) begin
                        s_nxt.ps = bcp_pkg::P_CA;
                    end else if (!i_rx_last && {s_r.first, u} == bcp_pkg::REFERENCE_LEARN_CMD) begin
                        s_nxt.ps = bcp_pkg::P_RT;
                    end else if (!i_rx_last && !s_r.learn_on
                                 && {s_r.first, u} == bcp_pkg::REFERENCE_SET_CMD) begin
                        s_nxt.ps = bcp_pkg::P_RSN;
                    end
                end
                bcp_pkg::P_CA: begin
                    if (i_rx_last && u == bcp_pkg::CH_PLUS) begin
                        s_nxt.auto_on = 1'b1;
                        s_nxt.mask = '0;
                        s_nxt.prev_mask = '0;
                    end else if (i_rx_last && u == bcp_pkg::CH_SLASH && s_r.auto_on) begin
                        s_nxt.mask = s_r.prev_mask;
                    end else if (i_rx_last && u == bcp_pkg::CH_MINUS && s_r.auto_on) begin
                        s_nxt.auto_on = 1'b0;
                        s_nxt.commit = 1'b1;
                    end
                end
                bcp_pkg::P_RT: begin
                    // A new learn request is refused until the previous one is ended.
                    if (i_rx_last && !s_r.learn_on && (u == bcp_pkg::CH_ONE || u == bcp_pkg::CH_TWO)) begin
                        s_nxt.learn_on = 1'b1;
                        s_nxt.learn_sel = u[1];
                        s_nxt.learn_done = 1'b0;
                    end else if (i_rx_last && u == bcp_pkg::CH_MINUS) begin
                        s_nxt.learn_on = 1'b0;
                    end
                end
                bcp_pkg::P_RSN: begin
                    if (!i_rx_last && (u == bcp_pkg::CH_ONE || u == bcp_pkg::CH_TWO)) begin
                        s_nxt.rs_sel = u[1];
                        s_nxt.ps = bcp_pkg::P_RST1;
                    end
                end
                bcp_pkg::P_RST1: begin
                    if (!i_rx_last && u >= 8'h30 && u <= 8'h39) begin
                        s_nxt.rs_tens = u[3:0];
                        s_nxt.ps = bcp_pkg::P_RST2;
                    end
                end
                bcp_pkg::P_RST2: begin
                    if (!i_rx_last && u >= 8'h30 && u <= 8'h39 && tval < 7'(bcp_pkg::NTYPES)) begin
                        s_nxt.rs_type = tval[3:0];
                        s_nxt.rs_cnt = '0;
                        s_nxt.ps = bcp_pkg::P_RSD;
                    end
                end
                bcp_pkg::P_RSD: begin
                    if (s_r.rs_cnt < 6'(bcp_pkg::REF_MAX)) begin
                        s_nxt.rs_cnt = s_r.rs_cnt + 6'h01;
                        s_nxt.ps = bcp_pkg::P_RSD;
                        if (i_rx_last) begin
                            s_nxt.ps = bcp_pkg::P_IDLE;
                            s_nxt.work_sel = s_r.rs_sel;
                            if (s_r.rs_sel) begin
                                s_nxt.map2 = spare;
                                s_nxt.len2 = s_nxt.rs_cnt[4:0];
                                s_nxt.typ2 = s_r.rs_type;
                            end else begin
                                s_nxt.map1 = spare;
                                s_nxt.len1 = s_nxt.rs_cnt[4:0];
                                s_nxt.typ1 = s_r.rs_type;
                            end
                        end
                    end
                end
                bcp_pkg::P_SKIP: begin
                end
                default: begin
                    s_nxt.ps = bcp_pkg::P_IDLE;
                end
            endcase
        end
        // Label formatter: header digits, then the contents one by one.
        case (s_r.fs)
            bcp_pkg::F_IDLE: begin
                if (start) begin
                    s_nxt.hdr = s_r.auto_on || s_r.detect;
                    s_nxt.store = s_r.learn_on && !s_r.learn_done && allowed;
                    s_nxt.keep = s_nxt.hdr || s_nxt.store;
                    s_nxt.detect = cc_hit; // A detect request landing now waits for the next label.
                    s_nxt.cnt = '0;
                    s_nxt.ltype = i_lbl_type;
                    s_nxt.ldig = i_lbl_digits;
                    if (s_r.auto_on) begin
                        s_nxt.prev_mask = s_r.mask;
                        s_nxt.mask[i_lbl_type] = 1'b1;
                    end
                    s_nxt.fs = s_nxt.hdr ? bcp_pkg::F_T1 : bcp_pkg::F_BODY;
                end
            end
            bcp_pkg::F_BODY: begin
                if (take) begin
                    s_nxt.ack = 1'b1;
                    if (s_r.keep) begin
                        s_nxt.tx_valid = 1'b1;
                        s_nxt.tx_data = i_lbl_bad ? bcp_pkg::CH_BAD : i_lbl_char;
                    end
                    if (s_r.store && s_r.cnt < 6'(bcp_pkg::REF_MAX)) begin
                        s_nxt.cnt = s_r.cnt + 6'h01;
                    end
                    if (i_lbl_last) begin
                        s_nxt.fs = bcp_pkg::F_IDLE;
                        if (s_r.store) begin
                            s_nxt.learn_done = 1'b1;
                            if (s_r.learn_sel) begin
                                s_nxt.map2 = spare;
                                s_nxt.len2 = s_nxt.cnt[4:0];
                                s_nxt.typ2 = s_r.ltype;
                            end else begin
                                s_nxt.map1 = spare;
                                s_nxt.len1 = s_nxt.cnt[4:0];
                                s_nxt.typ1 = s_r.ltype;
                            end
                        end
                    end
                end
            end
            default: begin
                // Header characters: type tens, ones, space, digits tens, ones, space.
                if (txfree) begin
                    s_nxt.tx_valid = 1'b1;
                    s_nxt.fs = bcp_pkg::bcp_fst_t'(s_r.fs + 3'h1);
                    case (s_r.fs)
                        bcp_pkg::F_T1: s_nxt.tx_data = bcp_dig({3'h0, s_r.ltype}, 1'b1);
                        bcp_pkg::F_T0: s_nxt.tx_data = bcp_dig({3'h0, s_r.ltype}, 1'b0);
                        bcp_pkg::F_D1: s_nxt.tx_data = bcp_dig(s_r.ldig, 1'b1);
                        bcp_pkg::F_D0: s_nxt.tx_data = bcp_dig(s_r.ldig, 1'b0);
                        default: s_nxt.tx_data = bcp_pkg::CH_SPACE;
                    endcase
                end
            end
        endcase
    end

    // State register.
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_r <= '0;
            s_r.map1 <= bcp_pkg::MAP1_RST;
            s_r.map2 <= bcp_pkg::MAP2_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_lbl_ack = s_r.ack;
    assign o_tx_valid = s_r.tx_valid;
    assign o_tx_data = s_r.tx_data;
    assign o_sensor1 = s_r.s1;
    assign o_sensor2 = s_r.s2;
    assign o_auto_active = s_r.auto_on;
    assign o_learn_active = s_r.learn_on;
    assign o_commit = s_r.commit;
    assign o_type_mask = s_r.mask;
    assign o_ref1_type = s_r.typ1;
    assign o_ref1_len = s_r.len1;
    assign o_ref2_type = s_r.typ2;
    assign o_ref2_len = s_r.len2;
    assign o_work_sel = s_r.work_sel;

    // Checks on the command and report behaviour.
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    property p_s1_on;
        i_rx_valid && i_rx_last && s_r.ps == bcp_pkg::P_IDLE && u == bcp_pkg::CH_PLUS
            |=> o_sensor1
                && (!o_tx_valid || $past(o_tx_valid || s_r.fs != bcp_pkg::F_IDLE));
    endproperty
    a_s1_on: assert property (p_s1_on) else $error("sensor one not raised");
    property p_s1_off;
        i_rx_valid && i_rx_last && s_r.ps == bcp_pkg::P_IDLE && u == bcp_pkg::CH_MINUS |=> !o_sensor1;
    endproperty
    a_s1_off: assert property (p_s1_off) else $error("sensor one not dropped");
    property p_s2;
        $changed(o_sensor2) |-> $past(i_rx_valid && i_rx_last && s_r.ps == bcp_pkg::P_IDLE);
    endproperty
    a_s2: assert property (p_s2) else $error("sensor two moved without command");
    property p_commit;
        $fell(o_auto_active) |-> o_commit ##1 !o_commit;
    endproperty
    a_commit: assert property (p_commit) else $error("commit pulse missing");
    property p_auto_on;
        i_rx_valid && i_rx_last && s_r.ps == bcp_pkg::P_CA && u == bcp_pkg::CH_PLUS
            |=> o_auto_active && o_type_mask == 16'h0000;
    endproperty
    a_auto_on: assert property (p_auto_on) else $error("auto setup not entered");
    property p_reject;
        i_rx_valid && i_rx_last && s_r.ps == bcp_pkg::P_CA && u == bcp_pkg::CH_SLASH
            && s_r.auto_on && !start |=> o_type_mask == $past(s_r.prev_mask);
    endproperty
    a_reject: assert property (p_reject) else $error("reject did not restore mask");
    property p_case;
        i_rx_valid && !i_rx_last && s_r.ps == bcp_pkg::P_IDLE && i_rx_data == 8'h63
            |=> s_r.ps == bcp_pkg::P_L2 && s_r.first == bcp_pkg::CH_C;
    endproperty
    a_case: assert property (p_case) else $error("lower case letter not accepted");
    property p_type_digit;
        s_r.fs == bcp_pkg::F_T1 && txfree
            |=> o_tx_valid && o_tx_data == 8'h30 + 8'(s_r.ltype / 4'd10) ##0 s_r.fs == bcp_pkg::F_T0;
    endproperty
    a_type_digit: assert property (p_type_digit) else $error("type tens digit wrong");
    property p_bad;
        take && s_r.keep && i_lbl_bad |=> o_tx_data == bcp_pkg::CH_BAD;
    endproperty
    a_bad: assert property (p_bad) else $error("marker missing for misread");
    property p_learn_filter;
        start && !s_r.auto_on && !s_r.detect && !allowed |=> !s_r.keep && !s_r.store;
    endproperty
    a_learn_filter: assert property (p_learn_filter) else $error("disabled type learned");
    property p_skip;
        s_r.ps == bcp_pkg::P_SKIP && !(take && i_lbl_last && s_r.store)
            |=> $stable(s_r.map1) && $stable(s_r.map2) && $stable(o_auto_active);
    endproperty
    a_skip: assert property (p_skip) else $error("skipped command changed state");
    c_auto: cover property (o_auto_active ##[1:200] o_commit);
    c_detect: cover property (s_r.detect ##[1:50] s_r.fs == bcp_pkg::F_BODY);
    c_learn: cover property ($rose(s_r.learn_done));
    c_rs: cover property (s_r.ps == bcp_pkg::P_RSD ##1 s_r.ps == bcp_pkg::P_IDLE);
endmodule : bcp_parser

// [hdl/bcp_pkg.sv]
// Purpose: Shared constants and types of the bar code command parser.
// Assumes: Commands arrive as bytes from an 8N1 receiver on the system clock.
// Notes: Letters are compared after folding to upper case.
package bcp_pkg;
    // Service link setting; the byte receiver outside is built for this rate.
    localparam int CLK_HZ = 40_000_000;
    localparam int LINK_BAUD = 9600;
    localparam int LINK_BITS = 8;
    localparam int LINK_BIT_CYC = CLK_HZ / LINK_BAUD;
    // Reference code storage.
    localparam int REF_MAX = 31;
    localparam int NTYPES = 16;
    localparam logic [1:0] MAP1_RST = 2'h0;
    localparam logic [1:0] MAP2_RST = 2'h1;
    // Command letter pairs, first letter in the upper byte.
    localparam logic [15:0] AUTO_SETUP_CMD = 16'h4341;
    localparam logic [15:0] REFERENCE_SET_CMD = 16'h5253;
    localparam logic [15:0] REFERENCE_LEARN_CMD = 16'h5254;
    localparam logic [15:0] CODE_DETECT_CMD = 16'h4343;
    // Single characters.
    localparam logic [7:0] CH_C = 8'h43;
    localparam logic [7:0] CH_R = 8'h52;
    localparam logic [7:0] CH_PLUS = 8'h2B;
    localparam logic [7:0] CH_MINUS = 8'h2D;
    localparam logic [7:0] CH_SLASH = 8'h2F;
    localparam logic [7:0] CH_S2_ON = 8'h28;
    localparam logic [7:0] CH_S2_OFF = 8'h29;
    localparam logic [7:0] CH_ONE = 8'h31;
    localparam logic [7:0] CH_TWO = 8'h32;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_BAD = 8'h5E;

    typedef enum logic [3:0] {
        P_IDLE = 4'h0, P_L2 = 4'h1, P_CA = 4'h2, P_RT = 4'h3, P_RSN = 4'h4,
        P_RST1 = 4'h5, P_RST2 = 4'h6, P_RSD = 4'h7, P_SKIP = 4'h8
    } bcp_pst_t;

    typedef enum logic [2:0] {
        F_IDLE = 3'h0, F_T1 = 3'h1, F_T0 = 3'h2, F_SP1 = 3'h3,
        F_D1 = 3'h4, F_D0 = 3'h5, F_SP2 = 3'h6, F_BODY = 3'h7
    } bcp_fst_t;
endpackage : bcp_pkg

// [hdl/bcp_ref_mem.sv]
// Purpose: Four banks of reference code characters, one write and one read port.
// Assumes: Writer and reader share the system clock.
// Notes: Read data is registered, so it follows the address by one cycle.
`timescale 1ns/1ps
module bcp_ref_mem #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Write port.
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    // Read port.
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Four banks of 32 characters are the least the bank swapping can use.
    if (AW < 7 || DW < 8) begin : g_check
        $error("bcp_ref_mem needs AW >= 7 and DW >= 8");
    end

    // The array has no reset; only the read register is cleared.
    always_ff @(posedge i_clock) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // Registered read port.
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule : bcp_ref_mem

// [sim/bcp_host_model.sv]
// Purpose: Host side sink that takes answer bytes from the parser.
// Assumes: Answer bytes are held by the parser until ready is seen high.
// Notes: Ready drops at random, so every byte may have to wait for the host.
`timescale 1ns/1ps
module bcp_host_model (
    // Clock.
    input wire logic i_clock,
    // Answer bytes.
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_ready
);
    // A slow host is the awkward case, so ready is low about one cycle in four.
    initial o_tx_ready = 1'b0;
    always @(negedge i_clock) begin
        o_tx_ready <= ($urandom_range(3) != 0);
    end
endmodule : bcp_host_model

// [sim/testbench.sv]
// Purpose: Self-checking bench of the command parser.
// Assumes: Inputs change at the falling edge; answers are taken by the host model.
// Notes: Expected answer bytes wait in a queue until the watcher sees them.
`timescale 1ns/1ps
module testbench;
    logic clk, rst, rx_valid, rx_last, lbl_valid, lbl_first, lbl_last, lbl_bad, lbl_ack;
    logic tx_valid, tx_ready, s1, s2, auto_on, learn_on, commit, work_sel, rd_sel;
    logic [7:0] rx_data, lbl_char, tx_data, rd_data;
    logic [3:0] lbl_type, r1t, r2t;
    logic [6:0] lbl_digits;
    logic [15:0] setup_types, type_mask;
    logic [4:0] r1l, r2l, rd_idx;
    logic [3:0] types[7] = '{4'h1, 4'h2, 4'h6, 4'h7, 4'h8, 4'hA, 4'hB};
    logic [7:0] exp_q[$];
    int fail_count = 0;
    int n_tests = 0;
    bcp_parser u_dut (.i_clock(clk), .i_sys_rst(rst), .i_rx_valid(rx_valid),
        .i_rx_data(rx_data), .i_rx_last(rx_last), .i_lbl_valid(lbl_valid),
        .i_lbl_first(lbl_first), .i_lbl_last(lbl_last), .i_lbl_bad(lbl_bad),
        .i_lbl_char(lbl_char), .i_lbl_type(lbl_type), .i_lbl_digits(lbl_digits),
        .o_lbl_ack(lbl_ack), .i_setup_types(setup_types), .o_tx_valid(tx_valid),
        .o_tx_data(tx_data), .i_tx_ready(tx_ready), .o_sensor1(s1), .o_sensor2(s2),
        .o_auto_active(auto_on), .o_learn_active(learn_on), .o_commit(commit),
        .o_type_mask(type_mask), .o_ref1_type(r1t), .o_ref1_len(r1l), .o_ref2_type(r2t),
        .o_ref2_len(r2l), .o_work_sel(work_sel), .i_ref_rd_sel(rd_sel),
        .i_ref_rd_idx(rd_idx), .o_ref_rd_data(rd_data));
    bcp_host_model u_host (.i_clock(clk), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
        .o_tx_ready(tx_ready));
    // Clock at 40 MHz.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Compares and counts; x or z never passes for a match.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    // Sends one command; returns once its effect has been registered.
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(negedge clk);
            {rx_valid, rx_last, rx_data} = {1'b1, i == s.len() - 1, s[i]};
        end
        @(negedge clk);
        {rx_valid, rx_last} = 2'b00;
    endtask : send
    // Presents a label char by char; mode 0 silent, 1 full report, 2 chars only.
    task automatic label(input logic [3:0] t, input string s, input int mode, input int bad);
        int w;
        logic [47:0] hd;
        hd = {8'h30 + 8'(t / 10), 8'h30 + 8'(t % 10), 8'h20, 8'h30 + 8'(s.len() / 10),
              8'h30 + 8'(s.len() % 10), 8'h20};
        if (mode == 1) for (int k = 5; k >= 0; k--) exp_q.push_back(hd[k*8+:8]);
        for (int i = 0; i < s.len(); i++) begin
            if (mode != 0) exp_q.push_back((i == bad) ? 8'h5E : s[i]);
            @(negedge clk);
            {lbl_valid, lbl_first, lbl_last, lbl_bad} = {1'b1, i == 0, i == s.len() - 1, i == bad};
            {lbl_char, lbl_type, lbl_digits} = {s[i], t, 7'(s.len())};
            w = 0;
            do begin
                @(posedge clk);
                w++;
            end while (lbl_ack !== 1'b1 && w < 300);
            check(16'(w < 300), 16'h1);
        end
        @(negedge clk);
        lbl_valid = 1'b0;
    endtask : label
    // Waits until every expected byte has come out, then looks for strays.
    task automatic drain();
        repeat (300) if (exp_q.size() != 0) @(posedge clk);
        repeat (8) @(posedge clk);
        check(16'(exp_q.size()), 16'h0);
    endtask : drain
    // Watcher: every byte the host takes is matched against the oldest note.
    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (exp_q.size() == 0) check(16'h1, 16'h0);
            else check(tx_data, exp_q.pop_front());
        end
    end
    // Main sequence.
    initial begin
        void'($urandom(71326));
        {rst, rx_valid, rx_last, lbl_valid, lbl_first, lbl_last, lbl_bad, rd_sel} = 8'h80;
        {rx_data, lbl_char, lbl_type, lbl_digits, rd_idx} = '0;
        setup_types = 16'h0004;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check({s1, s2, auto_on, learn_on, r1l, r2l, work_sel}, 16'h0);
        check(16'(bcp_pkg::LINK_BAUD), 16'h2580);
        send("+");
        check(s1, 1'b1);
        send("(");
        check(s2, 1'b1);
        send(")");
        check(s2, 1'b0);
        send("-");
        check(s1, 1'b0);
        send("xq");
        check({s1, s2, auto_on, learn_on, r1l, r2l}, 16'h0);
        send("ca+");
        check(auto_on, 1'b1);
        foreach (types[k]) label(types[k], "9A5", 1, $urandom_range(3));
        drain();
        send("CA/");
        send("CA-");
        check({commit, auto_on}, 2'b10);
        check(type_mask, 16'h05C6);
        send("cc");
        label(4'h8, "Q", 1, -1);
        drain();
        check(type_mask, 16'h05C6);
        label(4'h7, "Z", 0, -1);
        drain();
        send("RT1");
        check(learn_on, 1'b1);
        label(4'h2, "K7", 2, -1);
        drain();
        check({r1t, r1l}, {4'h2, 5'd2});
        send("RT-");
        check(learn_on, 1'b0);
        send("RT2");
        label(4'hB, "NO", 0, -1);
        drain();
        check(r2l, 5'd0);
        send("RS1071");
        check({r1t, r1l}, {4'h2, 5'd2});
        send("RT-");
        send("rs20912345");
        check({r2t, r2l, work_sel}, {4'h9, 5'd5, 1'b1});
        rd_sel = 1'b1;
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            rd_idx = 5'(i);
            @(posedge clk);
            #1;
            check(rd_data, 8'h31 + 8'(i));
        end
        send("RS106ABCDEFGHIJKLMNOPQRSTUVWXYZ012345");
        check({r1t, r1l}, {4'h2, 5'd2});
        send("RS106ABCDEFGHIJKLMNOPQRSTUVWXYZ01234");
        check({r1t, r1l, work_sel}, {4'h6, 5'd31, 1'b0});
        report_and_stop();
    end
    // Watchdog sized well beyond the few hundred cycles the tests need.
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
endmodule : testbench
